// >>> logic/cpu_local_bus_pkg.sv
// shared types and constants for the processor local bus interface
package cpu_local_bus_pkg;

  // ------------------------------------------------------------
  // cycle definition encodings
  // ------------------------------------------------------------
  localparam logic MIO_IO       = 1'b0;
  localparam logic MIO_MEM      = 1'b1;
  localparam logic WR_READ      = 1'b0;
  localparam logic WR_WRITE     = 1'b1;
  localparam logic DC_CONTROL   = 1'b0;
  localparam logic DC_DATA      = 1'b1;
  localparam logic ACT_N        = 1'b0;
  localparam logic IDLE_N       = 1'b1;

  // ------------------------------------------------------------
  // third-party master sequencer, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_HOLD    = 5'h02,
    ST_STROBE  = 5'h04,
    ST_WAIT    = 5'h08,
    ST_RELEASE = 5'h10
  } master_state_e;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic mem_io;
    logic wr_rd;
    logic data_ctrl;
  } cycle_def_s;

  typedef struct packed {
    logic mem_io;
    logic wr_rd;
  } master_cmd_s;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  // reset values of driven lines
  localparam pin_drive_s PIN_FLOAT_HI = '{o: IDLE_N, oe: 1'b0};

  // special cycle signature checked for stop grant
  localparam cycle_def_s SPECIAL_CYCLE = '{mem_io: MIO_IO, wr_rd: WR_WRITE,
                                          data_ctrl: DC_CONTROL};

endpackage : cpu_local_bus_pkg

// >>> logic/cpu_local_bus_interface.sv
// processor local bus interface: cycle decode, ready return, hold and side-band pins
// ------------------------------------------------------------
// Functional notes
// - address strobe is input for processor/master cycles, driven in dma cycles
// - low address strobe means cycle definition and address are valid
// - memory/io line low is io, high is memory; driven in dma cycles
// - write/read line low is read, high is write; driven in dma cycles
// - data/control input low is control cycle, high is data cycle
// - drive processor ready to end on-board memory or isa target cycles
// - float processor ready while local claim is sampled low
// - drive processor ready active when local target ready is seen low
// - non-maskable interrupt is signalled by a rising edge
// - interrupt output high while any valid request is pending
// - drive 16-bit size low when access is not on-board memory
// - float 16-bit size while local claim is low; target drives it
// - address-20 mask high in power-up and processor reset; low forces a20
// - pulse snoop strobe in dma cycles to invalidate the cache line
// - burst last sampled normally, driven low throughout dma cycles
// - drive burst ready in non-local cycles; input when local claim active
// - assert stop-clock request when power saving is entered
// - provide ignore-numeric-error output to the processor
// - processor ready from local ready, synchronised or passed through
// - with detection on, hold stop-clock request until stop grant cycle
// ------------------------------------------------------------
`timescale 1ns/100ps
module cpu_local_bus_interface
  import cpu_local_bus_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // processor bus, bidirectional lines split in three
  input  wire logic        i_addr_strobe_n,
  output logic             o_addr_strobe_n,
  output logic             o_addr_strobe_oe,
  input  wire logic        i_mem_io,
  output logic             o_mem_io,
  output logic             o_mem_io_oe,
  input  wire logic        i_wr_rd,
  output logic             o_wr_rd,
  output logic             o_wr_rd_oe,
  input  wire logic        i_data_ctrl,
  input  wire logic        i_burst_last_n,
  output logic             o_burst_last_n,
  output logic             o_burst_last_oe,
  input  wire logic        i_burst_ready_n,
  output logic             o_burst_ready_n,
  output logic             o_burst_ready_oe,
  output logic             o_proc_ready_n,
  output logic             o_proc_ready_oe,
  output logic             o_size16_n,
  output logic             o_size16_oe,
  output logic             o_snoop_addr_strobe_n,
  output logic             o_snoop_addr_strobe_oe,
  input  wire logic        i_local_claim_n,
  input  wire logic        i_local_target_ready_n,
  output logic             o_hold_req,
  input  wire logic        i_bus_hold_ack,
  output logic             o_nmi,
  output logic             o_irq_out,
  output logic             o_addr20_mask_n,
  output logic             o_stop_clock_req_n,
  input  wire logic        i_fpu_error_n,
  output logic             o_ignore_fpu_error_n,
  // chipset side
  input  wire logic        i_onboard_hit,
  input  wire logic        i_int_ready,
  input  wire logic        i_int_burst,
  input  wire logic        i_ready_sync_en,
  output cycle_def_s       o_cycle_def,
  output logic             o_cycle_start,
  output logic             o_cycle_active,
  output logic             o_cycle_done,
  input  wire logic        i_master_req,
  input  wire master_cmd_s i_master_cmd,
  input  wire logic        i_master_last,
  output logic             o_master_grant,
  output logic             o_master_xfer_done,
  input  wire logic        i_nmi_req,
  input  wire logic        i_irq_pending,
  input  wire logic        i_proc_reset,
  input  wire logic        i_a20_force,
  input  wire logic        i_power_save,
  input  wire logic        i_stop_grant_det_en,
  input  wire logic        i_stop_grant_code,
  input  wire logic        i_ignore_fpu_en,
  output logic             o_fpu_error
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_stop_grant(input cycle_def_s d, input logic code);
    is_stop_grant = (d == SPECIAL_CYCLE) && code;
  endfunction : is_stop_grant

  master_state_e state_reg;
  master_state_e state_next;
  logic          cyc_active_reg;
  cycle_def_s    cyc_def_reg;
  logic          cyc_onboard_reg;
  logic          claim_reg;
  logic          local_target_ready_n_sync_reg;
  logic          stop_req_reg;
  logic          grant_seen_reg;
  logic          cpu_start;
  logic          claim_now;
  logic          int_done;
  logic          local_done;
  logic          cyc_end;
  logic          master_phase;
  logic          master_ready;

  // processor or local master cycle, only while it still owns the bus
  assign cpu_start    = (i_addr_strobe_n == ACT_N) && !o_hold_req && !i_bus_hold_ack;
  assign claim_now    = claim_reg || (cyc_active_reg && i_local_claim_n == ACT_N);
  assign master_phase = (state_reg == ST_STROBE) || (state_reg == ST_WAIT);

  // ------------------------------------------------------------
  // processor cycle tracking
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      cyc_active_reg  <= 1'b0;
      cyc_def_reg     <= '0;
      cyc_onboard_reg <= 1'b0;
      claim_reg       <= 1'b0;
    end
    else if (cpu_start && !cyc_active_reg)
    begin
      cyc_active_reg  <= 1'b1;
      cyc_def_reg     <= '{mem_io: i_mem_io, wr_rd: i_wr_rd,
                           data_ctrl: i_data_ctrl};
      cyc_onboard_reg <= i_onboard_hit;
      claim_reg       <= 1'b0;
    end
    else if (cyc_end)
    begin
      cyc_active_reg <= 1'b0;
      claim_reg      <= 1'b0;
    end
    else if (cyc_active_reg && i_local_claim_n == ACT_N)
    begin
      claim_reg <= 1'b1;
    end
  end

  // a burst ends only on the ready that meets burst last
  assign int_done   = cyc_active_reg && !claim_now && i_int_ready &&
                      (!i_int_burst || i_burst_last_n == ACT_N);
  // with sync on, the cycle ends on the delayed ready or on burst ready meeting burst last
  assign local_done = cyc_active_reg && claim_now &&
                      ((i_ready_sync_en ? local_target_ready_n_sync_reg : master_ready) ||
                       (i_burst_ready_n == ACT_N && i_burst_last_n == ACT_N));
  assign cyc_end    = int_done || local_done;

  assign o_cycle_start  = cpu_start && !cyc_active_reg;
  assign o_cycle_active = cyc_active_reg;
  assign o_cycle_done   = cyc_end;
  assign o_cycle_def    = cyc_def_reg;

  // ------------------------------------------------------------
  // ready return
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      local_target_ready_n_sync_reg <= 1'b0;
    else
      local_target_ready_n_sync_reg <= (i_local_target_ready_n == ACT_N) && claim_now && !local_done;
  end

  // synchronised path costs one clock but tolerates late target ready
  assign master_ready = (i_local_target_ready_n == ACT_N);

  always_comb
  begin
    o_proc_ready_n   = IDLE_N;
    o_proc_ready_oe  = 1'b0;
    o_burst_ready_n  = IDLE_N;
    o_burst_ready_oe = 1'b0;
    if (cyc_active_reg && claim_now)
    begin
      // target owns burst ready; ready-return driven only when local ready seen
      if (i_ready_sync_en ? local_target_ready_n_sync_reg : master_ready)
      begin
        o_proc_ready_n  = ACT_N;
        o_proc_ready_oe = 1'b1;
      end
    end
    else if (cyc_active_reg)
    begin
      o_proc_ready_oe  = !i_int_burst;
      o_proc_ready_n   = (i_int_ready && !i_int_burst) ? ACT_N : IDLE_N;
      o_burst_ready_oe = 1'b1;
      o_burst_ready_n  = (i_int_ready && i_int_burst) ? ACT_N : IDLE_N;
    end
  end

  // size indication: unclaimed cycles outside on-board memory are 16-bit; claimed cycles float it
  always_comb
  begin
    o_size16_oe = cyc_active_reg && !claim_now && !cyc_onboard_reg;
    o_size16_n  = o_size16_oe ? ACT_N : IDLE_N;
  end

  // ------------------------------------------------------------
  // dma / isa master sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (i_master_req && !cyc_active_reg)
          state_next = ST_HOLD;
      ST_HOLD:
        if (i_bus_hold_ack)
          state_next = ST_STROBE;
      ST_STROBE:
        state_next = ST_WAIT;
      ST_WAIT:
        if (!i_bus_hold_ack)
          state_next = ST_RELEASE;
        else if (i_int_ready || master_ready)
          state_next = (i_master_last || !i_master_req) ? ST_RELEASE : ST_STROBE;
      ST_RELEASE:
        if (!i_bus_hold_ack)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_hold_req         <= 1'b0;
      o_master_grant     <= 1'b0;
      o_master_xfer_done <= 1'b0;
    end
    else
    begin
      o_hold_req         <= (state_next != ST_IDLE) && (state_next != ST_RELEASE);
      o_master_grant     <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_master_xfer_done <= (state_reg == ST_WAIT) && (state_next != ST_WAIT);
    end
  end

  // cycle lines driven from the master command while the bus is ours
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_addr_strobe_n        <= IDLE_N;
      o_addr_strobe_oe       <= 1'b0;
      o_mem_io               <= MIO_IO;
      o_mem_io_oe            <= 1'b0;
      o_wr_rd                <= WR_READ;
      o_wr_rd_oe             <= 1'b0;
      o_burst_last_n         <= IDLE_N;
      o_burst_last_oe        <= 1'b0;
      o_snoop_addr_strobe_n  <= IDLE_N;
      o_snoop_addr_strobe_oe <= 1'b0;
    end
    else
    begin
      o_addr_strobe_oe       <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_addr_strobe_n        <= (state_next == ST_STROBE) ? ACT_N : IDLE_N;
      o_mem_io_oe            <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_mem_io               <= i_master_cmd.mem_io;
      o_wr_rd_oe             <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_wr_rd                <= i_master_cmd.wr_rd;
      o_burst_last_oe        <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_burst_last_n         <= ACT_N;
      // a local master drives its own snoop strobe, so float outside our cycles
      o_snoop_addr_strobe_oe <= (state_next == ST_STROBE) || (state_next == ST_WAIT);
      o_snoop_addr_strobe_n  <= (state_next == ST_STROBE) ? ACT_N : IDLE_N;
    end
  end

  // ------------------------------------------------------------
  // interrupts, address-20 mask, numeric error
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_nmi     <= 1'b0;
      o_irq_out <= 1'b0;
    end
    else
    begin
      o_nmi     <= i_nmi_req;
      o_irq_out <= i_irq_pending;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_addr20_mask_n <= IDLE_N;
    else
      o_addr20_mask_n <= (i_proc_reset || !i_a20_force) ? IDLE_N : ACT_N;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_fpu_error          <= 1'b0;
      o_ignore_fpu_error_n <= IDLE_N;
    end
    else
    begin
      o_fpu_error          <= (i_fpu_error_n == ACT_N);
      o_ignore_fpu_error_n <= (i_ignore_fpu_en && i_fpu_error_n == ACT_N) ? ACT_N : IDLE_N;
    end
  end

  // ------------------------------------------------------------
  // stop clock
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      grant_seen_reg <= 1'b0;
    else if (!stop_req_reg)
      grant_seen_reg <= 1'b0;
    else if (o_cycle_start &&
             is_stop_grant('{mem_io: i_mem_io, wr_rd: i_wr_rd, data_ctrl: i_data_ctrl},
                           i_stop_grant_code))
      grant_seen_reg <= 1'b1;
  end

  // without the grant check the request simply follows power saving
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      stop_req_reg <= 1'b0;
    else if (i_power_save)
      stop_req_reg <= 1'b1;
    else if (i_stop_grant_det_en)
      stop_req_reg <= stop_req_reg && !grant_seen_reg;
    else
      stop_req_reg <= 1'b0;
  end

  assign o_stop_clock_req_n = stop_req_reg ? ACT_N : IDLE_N;

endmodule : cpu_local_bus_interface

// >>> verif/cpu_local_bus_sva.sv
// assertions on the processor local bus interface ports
`timescale 1ns/100ps
module cpu_local_bus_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_local_claim_n,
  input wire logic i_local_target_ready_n,
  input wire logic i_ready_sync_en,
  input wire logic o_cycle_active,
  input wire logic o_proc_ready_n,
  input wire logic o_proc_ready_oe,
  input wire logic o_size16_oe,
  input wire logic o_burst_ready_oe,
  input wire logic o_snoop_addr_strobe_n,
  input wire logic o_snoop_addr_strobe_oe,
  input wire logic o_addr_strobe_n,
  input wire logic o_addr_strobe_oe,
  input wire logic o_burst_last_n,
  input wire logic o_burst_last_oe,
  input wire logic i_bus_hold_ack,
  input wire logic o_hold_req,
  input wire logic o_mem_io_oe,
  input wire logic i_proc_reset,
  input wire logic o_addr20_mask_n,
  input wire logic i_power_save,
  input wire logic o_stop_clock_req_n
);
  // ------
  // properties
  // ------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_claim_float;
    o_cycle_active && !i_local_claim_n && i_local_target_ready_n
      && $past(i_local_target_ready_n) |-> !o_proc_ready_oe;
  endproperty
  a_claim_float: assert property (p_claim_float) else $error("ready driven in claim");
  property p_local_ready;
    o_cycle_active && !i_local_claim_n && !i_local_target_ready_n && !i_ready_sync_en
      |-> o_proc_ready_oe && !o_proc_ready_n;
  endproperty
  a_local_ready: assert property (p_local_ready) else $error("ready not passed");
  property p_size_float;
    o_cycle_active && !i_local_claim_n |-> !o_size16_oe;
  endproperty
  a_size_float: assert property (p_size_float) else $error("size16 driven in claim");
  property p_burst_float;
    o_cycle_active && !i_local_claim_n |-> !o_burst_ready_oe;
  endproperty
  a_burst_float: assert property (p_burst_float) else $error("burst ready driven");
  property p_snoop;
    o_snoop_addr_strobe_oe && !o_snoop_addr_strobe_n |-> !o_addr_strobe_n
      ##1 o_snoop_addr_strobe_n;
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop strobe not one cycle");
  property p_burst_last_n;
    o_addr_strobe_oe |-> o_burst_last_oe && !o_burst_last_n;
  endproperty
  a_burst_last_n: assert property (p_burst_last_n) else $error("burst last not low");
  // driving the strobe only once the processor has let go of the bus
  property p_strobe_own;
    o_addr_strobe_oe |-> i_bus_hold_ack;
  endproperty
  a_strobe_own: assert property (p_strobe_own) else $error("strobe driven without ack");
  property p_release;
    $fell(o_hold_req) |-> !o_addr_strobe_oe && !o_mem_io_oe;
  endproperty
  a_release: assert property (p_release) else $error("lines held after hold");
  property p_a20;
    i_proc_reset |=> o_addr20_mask_n;
  endproperty
  a_a20: assert property (p_a20) else $error("a20 mask low in reset");
  property p_stop;
    i_power_save [*2] |-> !o_stop_clock_req_n;
  endproperty
  a_stop: assert property (p_stop) else $error("stop request missing");
endmodule : cpu_local_bus_sva

bind cpu_local_bus_interface cpu_local_bus_sva chk_u (.i_ref_clk, .i_rst_n, .i_local_claim_n,
  .i_local_target_ready_n, .i_ready_sync_en, .o_cycle_active, .o_proc_ready_n,
  .o_proc_ready_oe, .o_size16_oe, .o_burst_ready_oe, .o_snoop_addr_strobe_n,
  .o_snoop_addr_strobe_oe, .o_addr_strobe_n, .o_addr_strobe_oe, .o_burst_last_n,
  .o_burst_last_oe, .i_bus_hold_ack, .o_hold_req, .o_mem_io_oe, .i_proc_reset,
  .o_addr20_mask_n, .i_power_save, .o_stop_clock_req_n);

// >>> verif/proc_bus_model.sv
// processor side model: address strobe and hold acknowledge
`timescale 1ns/100ps
module proc_bus_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_hold_req,
  input  wire logic [3:0] i_ack_delay,
  output logic            o_addr_strobe_n,
  output logic            o_bus_hold_ack
);
  logic [3:0] wait_cnt = 4'h0;
  initial o_addr_strobe_n = 1'b1;
  initial o_bus_hold_ack = 1'b0;
  // ack waits for own address strobe to go high; slow ack via i_ack_delay
  always @(negedge i_ref_clk)
  begin
    if (!i_hold_req)
    begin
      o_bus_hold_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt >= i_ack_delay && o_addr_strobe_n)
      o_bus_hold_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
  task automatic strobe();
    o_addr_strobe_n = 1'b0;
    @(negedge i_ref_clk);
    o_addr_strobe_n = 1'b1;
  endtask : strobe
endmodule : proc_bus_model

// >>> verif/tb.sv
// self-checking bench for the processor local bus interface
`timescale 1ns/100ps
module tb;
  import cpu_local_bus_pkg::*;
  // ------
  // stimulus and wires
  // ------
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0;
  logic i_data_ctrl, i_local_claim_n, i_local_target_ready_n, i_fpu_error_n, i_onboard_hit;
  logic i_int_ready, i_int_burst, i_ready_sync_en, i_master_req, i_master_last, i_nmi_req;
  logic i_irq_pending, i_proc_reset, i_a20_force, i_power_save, i_stop_grant_det_en;
  logic i_stop_grant_code, i_ignore_fpu_en, mio_d, wr_d, burst_last_n_d, burst_ready_n_d, ads_p;
  logic o_addr_strobe_n, o_addr_strobe_oe, o_mem_io, o_mem_io_oe, o_wr_rd, o_wr_rd_oe;
  logic o_burst_last_n, o_burst_last_oe, o_burst_ready_n, o_burst_ready_oe, o_proc_ready_n;
  logic o_proc_ready_oe, o_size16_n, o_size16_oe, o_snoop_addr_strobe_n, o_snoop_addr_strobe_oe;
  logic o_hold_req, i_bus_hold_ack, o_nmi, o_irq_out, o_addr20_mask_n, o_stop_clock_req_n;
  logic o_ignore_fpu_error_n, o_cycle_start, o_cycle_active, o_cycle_done, o_master_grant;
  logic o_master_xfer_done, o_fpu_error;
  logic [3:0] ack_dly;
  master_cmd_s i_master_cmd;
  cycle_def_s o_cycle_def;
  int errors = 0, checks_done = 0, n, starts = 0;
  // shared lines take the level of whichever side has its driver on
  wire i_addr_strobe_n = o_addr_strobe_oe ? o_addr_strobe_n : ads_p;
  wire i_mem_io = o_mem_io_oe ? o_mem_io : mio_d;
  wire i_wr_rd = o_wr_rd_oe ? o_wr_rd : wr_d;
  wire i_burst_last_n = o_burst_last_oe ? o_burst_last_n : burst_last_n_d;
  wire i_burst_ready_n = o_burst_ready_oe ? o_burst_ready_n : burst_ready_n_d;
  always #5 i_ref_clk = ~i_ref_clk;
  // accepted cycle starts, counted where the design samples them
  always @(posedge i_ref_clk)
    if (o_cycle_start === 1'b1)
      starts++;
  cpu_local_bus_interface dut_u (.*);
  proc_bus_model p_u (.i_ref_clk, .i_hold_req(o_hold_req), .i_ack_delay(ack_dly),
    .o_addr_strobe_n(ads_p), .o_bus_hold_ack(i_bus_hold_ack));
  // ------
  // scenarios
  // ------
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic t_proc(input logic mio, input logic wr, input logic dc, input logic onb);
    int s0 = starts;
    @(negedge i_ref_clk);
    mio_d = mio;
    wr_d = wr;
    i_data_ctrl = dc;
    i_onboard_hit = onb;
    p_u.strobe();
    i_int_ready = 1'b1;
    #1;
    chk("cycle_def", {1'b0, mio, wr, dc}, {1'b0, o_cycle_def});
    chk("size16", {3'h0, !onb}, {2'h0, o_snoop_addr_strobe_oe, o_size16_oe & !o_size16_n});
    chk("proc_ready", 4'he, {o_cycle_done, o_burst_ready_oe, o_proc_ready_oe, o_proc_ready_n});
    @(negedge i_ref_clk);
    i_int_ready = 1'b0;
    #1;
    chk("active", 4'h0, {3'h0, o_cycle_active});
    chk("starts", 4'h1, 4'(starts - s0));
  endtask : t_proc
  task automatic t_claim(input logic sync);
    @(negedge i_ref_clk);
    i_ready_sync_en = sync;
    i_onboard_hit = 1'b0;
    p_u.strobe();
    i_local_claim_n = 1'b0;
    #1;
    chk("claim_oe", 4'h0, {1'b0, o_proc_ready_oe, o_size16_oe, o_burst_ready_oe});
    @(negedge i_ref_clk);
    i_local_target_ready_n = 1'b0;
    if (sync)
      @(negedge i_ref_clk);
    #1;
    chk("local_ready", 4'h2, {2'h0, o_proc_ready_oe, o_proc_ready_n});
    @(negedge i_ref_clk);
    {i_local_claim_n, i_local_target_ready_n} = 2'h3;
    @(negedge i_ref_clk);
    chk("claim_end", 4'h0, {3'h0, o_cycle_active});
  endtask : t_claim
  task automatic t_master(input master_cmd_s cmd, input logic [3:0] dly);
    int s0 = starts;
    @(negedge i_ref_clk);
    ack_dly = dly;
    i_master_cmd = cmd;
    i_master_last = 1'b1;
    i_master_req = 1'b1;
    for (n = 0; n < 30 && !(o_addr_strobe_oe === 1'b1 && o_addr_strobe_n === 1'b0); n++)
      @(negedge i_ref_clk);
    i_master_req = 1'b0;
    chk("strobe", 4'ha, {o_addr_strobe_oe, o_addr_strobe_n, o_snoop_addr_strobe_oe, o_snoop_addr_strobe_n});
    chk("cmd", {2'h3, cmd}, {o_mem_io_oe, o_wr_rd_oe, o_mem_io, o_wr_rd});
    chk("burst_last", 4'h6, {1'b0, o_master_grant, o_burst_last_oe, o_burst_last_n});
    i_local_target_ready_n = 1'b0;
    for (n = 0; n < 10 && o_master_xfer_done !== 1'b1; n++)
      @(negedge i_ref_clk);
    i_local_target_ready_n = 1'b1;
    for (n = 0; n < 10 && o_hold_req !== 1'b0; n++)
      @(negedge i_ref_clk);
    chk("release", 4'h0, {o_hold_req, o_mem_io_oe, o_addr_strobe_oe, o_burst_last_oe});
    chk("no_start", 4'h0, 4'(starts - s0));
    repeat (2) @(negedge i_ref_clk);
  endtask : t_master
  task automatic t_burst(input logic claim);
    @(negedge i_ref_clk);
    i_int_burst = 1'b1;
    i_onboard_hit = 1'b1;
    p_u.strobe();
    {i_local_claim_n, i_int_ready, burst_ready_n_d} = {!claim, 2'h2};
    #1;
    chk("burst_mid", {1'b0, !claim, 2'h0},
      {o_cycle_done, o_burst_ready_oe, i_burst_ready_n, o_proc_ready_oe});
    @(negedge i_ref_clk);
    burst_last_n_d = 1'b0;
    #1;
    chk("burst_end", {1'b1, !claim, 2'h0},
      {o_cycle_done, o_burst_ready_oe, i_burst_ready_n, o_proc_ready_oe});
    @(negedge i_ref_clk);
    {i_local_claim_n, i_int_ready, burst_ready_n_d, burst_last_n_d, i_int_burst} = 5'h16;
    chk("burst_idle", 4'h0, {3'h0, o_cycle_active});
  endtask : t_burst
  task automatic t_side();
    @(negedge i_ref_clk);
    {i_nmi_req, i_irq_pending, i_a20_force, i_fpu_error_n, i_ignore_fpu_en, i_power_save} = 6'h3b;
    @(negedge i_ref_clk);
    chk("side_on", 4'h0, {!o_nmi, !o_irq_out, o_addr20_mask_n, o_stop_clock_req_n});
    chk("fpu", 4'h2, {2'h0, o_fpu_error, o_ignore_fpu_error_n});
    {i_irq_pending, i_proc_reset, i_power_save} = 3'h2;
    @(negedge i_ref_clk);
    chk("side_off", 4'h3, {1'b0, o_irq_out, o_addr20_mask_n, o_stop_clock_req_n});
    // with grant detection the request must outlive power saving
    {i_proc_reset, i_a20_force, i_stop_grant_det_en, i_power_save} = 4'h3;
    @(negedge i_ref_clk);
    i_power_save = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk("stop_hold", 4'h0, {3'h0, o_stop_clock_req_n});
    i_stop_grant_code = 1'b1;
    t_proc(MIO_IO, WR_WRITE, DC_CONTROL, 1'b1);
    @(negedge i_ref_clk);
    chk("stop_free", 4'h1, {3'h0, o_stop_clock_req_n});
  endtask : t_side
  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // ------
  // main sequence and watchdog
  // ------
  initial
  begin
    {i_data_ctrl, i_onboard_hit, i_int_ready, i_int_burst, i_ready_sync_en, i_master_req,
      i_master_last, i_nmi_req, i_irq_pending, i_proc_reset, i_a20_force, i_power_save,
      i_stop_grant_det_en, i_stop_grant_code, i_ignore_fpu_en, mio_d, wr_d} = '0;
    {i_local_claim_n, i_local_target_ready_n, i_fpu_error_n, burst_last_n_d, burst_ready_n_d} = 5'h1f;
    i_master_cmd = '0;
    ack_dly = 4'h0;
    repeat (12) @(negedge i_ref_clk);
    chk("reset_oe", 4'h0, {o_addr_strobe_oe, o_proc_ready_oe, o_snoop_addr_strobe_oe, o_hold_req});
    chk("reset_hi", 4'h7, {1'b0, o_addr20_mask_n, o_stop_clock_req_n, o_ignore_fpu_error_n});
    i_rst_n = 1'b1;
    for (int k = 0; k < 8; k++)
      t_proc(k[2], k[1], k[0], k[0]);
    t_claim(1'b0);
    t_claim(1'b1);
    t_burst(1'b0);
    t_burst(1'b1);
    t_master('{MIO_MEM, WR_WRITE}, 4'h0);
    t_master('{MIO_IO, WR_READ}, 4'h3);
    t_side();
    summarize();
  end
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
endmodule : tb
